// >>> shared/swl_consts.svh
// Constants for the single-wire slave memory access block.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH
// ----------------------------------------
// Clock (MHz) and timing (ns)
// ----------------------------------------
`define SWL_CLK_MHZ       125
`define SWL_LOW0_NS       120000
`define SWL_SAMPLE_NS     30000
`define SWL_HOLD_NS       30000
`define SWL_PDH_NS        30000
`define SWL_PDL_NS        120000
`define SWL_COPY_NS       10000000
`define SWL_CNT_W         24
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SWL_OP_RD_ADDR    8'h33
`define SWL_OP_MATCH      8'h55
`define SWL_OP_SKIP       8'hCC
`define SWL_OP_SEARCH     8'hF0
`define SWL_OP_READ       8'h69
`define SWL_OP_READ_CRC   8'h66
`define SWL_OP_WRITE      8'h6C
`define SWL_OP_COPY       8'h48
`define SWL_OP_RECALL     8'hB8
`define SWL_OP_LOCK       8'h6A
// ----------------------------------------
// Memory map
// ----------------------------------------
`define SWL_CTRL_ADDR     8'h1F
`define SWL_ARM_BIT       6
`define SWL_BUSY_BIT      7
`define SWL_BLK0_BASE     8'h20
`define SWL_BLK0_SIZE     32
`define SWL_BLK1_BASE     8'h80
`define SWL_BLK1_SIZE     16
`define SWL_EE_BYTES      48
`define SWL_RAM_BASE      8'h40
`define SWL_RAM_BYTES     64
`define SWL_CRC_POLY      8'h8C
`define SWL_CRC_PAGE      8
`define SWL_FIFO_DEPTH    4
`endif

// >>> shared/swl_pkg.sv
// Types for the single-wire slave memory access block.
// Assumes swl_consts.svh is on the include path.
`include "swl_consts.svh"
package swl_pkg;
  // ----------------------------------------
  // Protocol states
  // ----------------------------------------
  typedef enum logic [12:0] {
    S_IDLE  = 13'h0001,
    S_RSTL  = 13'h0002,
    S_PDH   = 13'h0004,
    S_PDL   = 13'h0008,
    S_NET   = 13'h0010,
    S_RDROM = 13'h0020,
    S_MATCH = 13'h0040,
    S_SRCH  = 13'h0080,
    S_FCMD  = 13'h0100,
    S_MADDR = 13'h0200,
    S_READ  = 13'h0400,
    S_WRITE = 13'h0800,
    S_DONE  = 13'h1000
  } state_t;

  typedef logic [`SWL_CNT_W-1:0] cnt_t;

  // Line handling
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    cnt_t low_cnt;
    logic slot_act;
    cnt_t slot_cnt;
    logic drv;
    cnt_t drv_cnt;
  } line_st_t;

  typedef struct packed {
    state_t   fsm;
    line_st_t ln;
    logic [6:0] bit_cnt;
    logic [1:0] phase;
    logic [7:0] sh;
    logic       mism;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] crc;
    logic [7:0] page;
    logic       lock_ok;
    logic       arm_fresh;
    logic       lock_arm;
    logic [1:0] locks;
    logic       busy;
    logic       copy_pend;
    logic       copy_blk;
    cnt_t       copy_cnt;
    logic [`SWL_EE_BYTES-1:0][7:0]  shadow;
    logic [`SWL_EE_BYTES-1:0][7:0]  cells;
    logic [`SWL_RAM_BYTES-1:0][7:0] ram;
  } st_t;
endpackage

// >>> design/swl_slave.sv
// Single-wire slave: line timing, net address commands, memory functions, FIFO.
// Assumes one open-drain line with external pull-up, sampled asynchronously.
`include "swl_consts.svh"

// ----------------------------------------
// Byte FIFO
// ----------------------------------------
module swl_fifo
  import swl_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = `SWL_FIFO_DEPTH
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_flush,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           rd;
    logic [AW-1:0]           wr;
    logic [AW:0]             cnt;
  } fifo_st_t;
  fifo_st_t q;
  fifo_st_t d;
  logic     push;
  logic     pop;

  assign o_ready = (q.cnt != (AW+1)'(DEPTH));
  assign o_valid = (q.cnt != '0);
  assign o_data  = q.mem[q.rd];

  always_comb begin
    d    = q;
    push = i_valid && o_ready;
    pop  = i_ready && o_valid;
    if (push) begin
      d.mem[q.wr] = i_data;
      d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (i_flush) begin
      d.rd  = '0;
      d.wr  = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ----------------------------------------
// Slave top
// ----------------------------------------
// Notes on behaviour
// - CRC byte sent after every eight bytes in read-with-CRC mode.
// - Host checks CRC; device never stops on mismatch.
// - Line driven only low, through enable; never driven high.
// - Low longer than limit is a reset pulse; transaction abandoned.
// - Order: reset, one net command, function commands, data.
// - After reset pulse rises, wait then drive presence pulse.
// - Opcode 33h sends the 64-bit net address.
// - Opcode 55h: only matching address proceeds; others wait for reset.
// - Opcode CCh goes straight to function commands.
// - Opcode F0h: per bit send bit, complement, then read master bit.
// - Opcode 69h: data LSb first after address, address increments per byte.
// - Reads wrap from FFh to 00h until reset.
// - Reset ends reads at any bit; reserved reads return zero.
// - EEPROM addresses read shadow RAM, not cells.
// - Opcode 6Ch: writes LSb first, auto-increment, wrap to 00h.
// - Read-only, reserved, locked and partial byte writes discarded.
// - EEPROM writes update shadow only; cells change on copy.
// - Opcode 48h copies shadow of unlocked block into cells.
// - Copy busy flag set for copy time; EEPROM writes ignored meanwhile.
// - Opcode B8h reloads shadow block from its cells.
// - Opcode 6Ah locks block permanently when freshly armed.
// - Arm bit is bit 6 of 1Fh, set just before lock.
// - Net address top byte is CRC of its lower 56 bits.
module swl_slave
  import swl_pkg::*;
#(
  parameter logic [7:0]  FAMILY     = 8'h5A,        // Arbitrary value
  parameter logic [47:0] SERIAL     = 48'h0123_4567_89AB, // Arbitrary value
  parameter int LOW0_CYC   = (`SWL_LOW0_NS * `SWL_CLK_MHZ + 999) / 1000,
  parameter int SAMPLE_CYC = (`SWL_SAMPLE_NS * `SWL_CLK_MHZ + 999) / 1000,
  parameter int HOLD_CYC   = (`SWL_HOLD_NS * `SWL_CLK_MHZ) / 1000,
  parameter int PDH_CYC    = (`SWL_PDH_NS * `SWL_CLK_MHZ + 999) / 1000,
  parameter int PDL_CYC    = (`SWL_PDL_NS * `SWL_CLK_MHZ + 999) / 1000,
  parameter int COPY_CYC   = (`SWL_COPY_NS * `SWL_CLK_MHZ + 999) / 1000
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_line,
  output logic      o_line,
  output logic      o_line_oe,
  output logic      o_copy_busy
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    return fb ? ((c >> 1) ^ `SWL_CRC_POLY) : (c >> 1);
  endfunction

  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crc_bit(r, b[i]);
    end
    return r;
  endfunction

  function automatic logic [7:0] crc_56(input logic [55:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 56; i++) begin
      r = crc_bit(r, v[i]);
    end
    return r;
  endfunction

  // Block hit and shadow index of an address
  function automatic logic ee_hit(input logic [7:0] a);
    return (a >= `SWL_BLK0_BASE && a < `SWL_BLK0_BASE + 8'(`SWL_BLK0_SIZE)) ||
           (a >= `SWL_BLK1_BASE && a < `SWL_BLK1_BASE + 8'(`SWL_BLK1_SIZE));
  endfunction

  function automatic logic ee_blk(input logic [7:0] a);
    return (a >= `SWL_BLK1_BASE);
  endfunction

  function automatic logic [5:0] ee_idx(input logic [7:0] a);
    return ee_blk(a) ? 6'(a - `SWL_BLK1_BASE + 8'(`SWL_BLK0_SIZE))
                     : 6'(a - `SWL_BLK0_BASE);
  endfunction

  function automatic logic ram_hit(input logic [7:0] a);
    return (a >= `SWL_RAM_BASE && a < `SWL_RAM_BASE + 8'(`SWL_RAM_BYTES));
  endfunction

  localparam logic [63:0] NET_ADDR = {crc_56({SERIAL, FAMILY}), SERIAL, FAMILY};

  st_t  q;
  st_t  d;
  logic fifo_push;
  logic fifo_ready;
  logic [7:0] fifo_in;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_out;
  logic fifo_flush;

  function automatic logic [7:0] mem_read(input logic [7:0] a);
    logic [7:0] ctrl;
    ctrl = 8'h00;
    ctrl[`SWL_ARM_BIT]  = q.lock_arm;
    ctrl[`SWL_BUSY_BIT] = q.busy;
    ctrl[1:0]           = q.locks;
    if (ee_hit(a)) begin
      return q.shadow[ee_idx(a)];
    end else if (ram_hit(a)) begin
      return q.ram[6'(a - `SWL_RAM_BASE)];
    end else if (a == `SWL_CTRL_ADDR) begin
      return ctrl;
    end
    return 8'h00;
  endfunction

  swl_fifo #(
    .W     (8),
    .DEPTH (`SWL_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_flush   (fifo_flush),
    .i_valid   (fifo_push),
    .o_ready   (fifo_ready),
    .i_data    (fifo_in),
    .o_valid   (fifo_valid),
    .i_ready   (fifo_pop),
    .o_data    (fifo_out)
  );

  assign o_line      = 1'b0;
  assign o_line_oe   = q.ln.drv;
  assign o_copy_busy = q.busy;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic       fall;
    logic       rise;
    logic       bit_ev;
    logic       rxb;
    logic       tx_mode;
    logic       tx_bit;
    logic [7:0] byte_in;
    logic [5:0] bi;
    logic [6:0] bc;
    fall       = 1'b0;
    rise       = 1'b0;
    bit_ev     = 1'b0;
    rxb        = 1'b0;
    tx_mode    = 1'b0;
    tx_bit     = 1'b1;
    byte_in    = 8'h00;
    bi         = 6'd0;
    bc         = 7'd0;
    d          = q;
    fifo_push  = 1'b0;
    fifo_in    = 8'h00;
    fifo_pop   = 1'b0;
    fifo_flush = 1'b0;

    // Only sync2 feeds logic; sync1 is metastability guard
    d.ln.sync1 = i_line;
    d.ln.sync2 = q.ln.sync1;
    d.ln.prev  = q.ln.sync2;
    fall = q.ln.prev && !q.ln.sync2;
    rise = !q.ln.prev && q.ln.sync2;
    d.ln.low_cnt = q.ln.sync2 ? '0 :
                   (q.ln.low_cnt == cnt_t'(LOW0_CYC)) ? q.ln.low_cnt : q.ln.low_cnt + 1'b1;

    // Release read-zero drive after hold time, presence drive after PDL_CYC
    if (q.ln.drv) begin
      d.ln.drv_cnt = q.ln.drv_cnt + 1'b1;
      if (q.fsm == S_PDL) begin
        if (q.ln.drv_cnt == cnt_t'(PDL_CYC - 1)) begin
          d.ln.drv = 1'b0;
          d.fsm    = S_NET;
          d.bit_cnt = '0;
        end
      end else if (q.ln.drv_cnt == cnt_t'(HOLD_CYC - 1)) begin
        d.ln.drv = 1'b0;
      end
    end

    // Transmit bit source for the current state
    bc = q.bit_cnt;
    case (q.fsm)
      S_RDROM: begin
        tx_mode = 1'b1;
        tx_bit  = NET_ADDR[6'(bc)];
      end
      S_SRCH: begin
        tx_mode = (q.phase != 2'd2);
        tx_bit  = (q.phase == 2'd0) ? NET_ADDR[6'(bc)] : !NET_ADDR[6'(bc)];
      end
      S_READ: begin
        tx_mode = 1'b1;
        tx_bit  = fifo_valid ? fifo_out[3'(bc)] : 1'b1;
      end
      default: begin
        tx_mode = 1'b0;
        tx_bit  = 1'b1;
      end
    endcase

    // Slot timing in protocol states; host pause just idles high
    if (fall && (q.fsm inside {S_NET, S_RDROM, S_MATCH, S_SRCH, S_FCMD,
                               S_MADDR, S_READ, S_WRITE})) begin
      d.ln.slot_act = 1'b1;
      d.ln.slot_cnt = '0;
      if (tx_mode && !tx_bit) begin
        d.ln.drv     = 1'b1;
        d.ln.drv_cnt = '0;
      end
    end else if (q.ln.slot_act) begin
      d.ln.slot_cnt = q.ln.slot_cnt + 1'b1;
      if (q.ln.slot_cnt == cnt_t'(SAMPLE_CYC - 1)) begin
        d.ln.slot_act = 1'b0;
        bit_ev = 1'b1;
        rxb    = q.ln.sync2;
      end
    end

    byte_in = {rxb, q.sh[7:1]};
    bi      = 6'(q.bit_cnt);

    // ----------------------------------------
    // Protocol sequence
    // ----------------------------------------
    case (q.fsm)
      S_IDLE, S_DONE: begin
      end
      S_RSTL: begin
        if (rise) begin
          d.fsm = S_PDH;
          d.ln.drv_cnt = '0;
        end
      end
      S_PDH: begin
        d.ln.drv_cnt = q.ln.drv_cnt + 1'b1;
        if (q.ln.drv_cnt == cnt_t'(PDH_CYC - 1)) begin
          d.fsm        = S_PDL;
          d.ln.drv     = 1'b1;
          d.ln.drv_cnt = '0;
        end
      end
      S_PDL: begin
      end
      S_NET: begin
        if (bit_ev) begin
          d.sh      = byte_in;
          d.bit_cnt = q.bit_cnt + 1'b1;
          if (q.bit_cnt == 7'd7) begin
            d.bit_cnt = '0;
            d.mism    = 1'b0;
            d.phase   = 2'd0;
            case (byte_in)
              `SWL_OP_RD_ADDR: d.fsm = S_RDROM;
              `SWL_OP_MATCH:   d.fsm = S_MATCH;
              `SWL_OP_SKIP:    d.fsm = S_FCMD;
              `SWL_OP_SEARCH:  d.fsm = S_SRCH;
              default:         d.fsm = S_DONE;
            endcase
          end
        end
      end
      S_RDROM: begin
        if (bit_ev) begin
          d.bit_cnt = q.bit_cnt + 1'b1;
          if (q.bit_cnt == 7'd63) begin
            d.bit_cnt = '0;
            d.fsm     = S_FCMD;
          end
        end
      end
      S_MATCH: begin
        if (bit_ev) begin
          d.mism    = q.mism || (rxb != NET_ADDR[bi]);
          d.bit_cnt = q.bit_cnt + 1'b1;
          if (q.bit_cnt == 7'd63) begin
            d.bit_cnt = '0;
            d.fsm     = d.mism ? S_DONE : S_FCMD;
          end
        end
      end
      S_SRCH: begin
        if (bit_ev) begin
          if (q.phase != 2'd2) begin
            d.phase = q.phase + 1'b1;
          end else if (rxb != NET_ADDR[bi]) begin
            d.fsm = S_DONE;
          end else begin
            d.phase   = 2'd0;
            d.bit_cnt = q.bit_cnt + 1'b1;
            if (q.bit_cnt == 7'd63) begin
              d.bit_cnt = '0;
              d.fsm     = S_FCMD;
            end
          end
        end
      end
      S_FCMD: begin
        if (bit_ev) begin
          d.sh      = byte_in;
          d.bit_cnt = q.bit_cnt + 1'b1;
          if (q.bit_cnt == 7'd7) begin
            d.bit_cnt   = '0;
            d.cmd       = byte_in;
            d.lock_ok   = q.arm_fresh;
            d.arm_fresh = 1'b0;
            d.fsm = (byte_in inside {`SWL_OP_READ, `SWL_OP_READ_CRC, `SWL_OP_WRITE,
                     `SWL_OP_COPY, `SWL_OP_RECALL, `SWL_OP_LOCK}) ? S_MADDR : S_DONE;
          end
        end
      end
      S_MADDR: begin
        if (bit_ev) begin
          d.sh      = byte_in;
          d.bit_cnt = q.bit_cnt + 1'b1;
          if (q.bit_cnt == 7'd7) begin
            d.bit_cnt = '0;
            d.addr    = byte_in;
            d.crc     = 8'h00;
            d.page    = 8'h00;
            d.fsm     = S_FCMD;
            case (q.cmd)
              `SWL_OP_READ, `SWL_OP_READ_CRC: d.fsm = S_READ;
              `SWL_OP_WRITE: d.fsm = S_WRITE;
              `SWL_OP_COPY: begin
                if (ee_hit(byte_in) && !q.locks[ee_blk(byte_in)] && !q.busy) begin
                  d.copy_pend = 1'b1;
                  d.copy_blk  = ee_blk(byte_in);
                end
              end
              `SWL_OP_RECALL: begin
                if (ee_hit(byte_in)) begin
                  for (int i = 0; i < `SWL_EE_BYTES; i++) begin
                    if ((i >= `SWL_BLK0_SIZE) == ee_blk(byte_in)) begin
                      d.shadow[i] = q.cells[i];
                    end
                  end
                end
              end
              `SWL_OP_LOCK: begin
                if (ee_hit(byte_in) && q.lock_ok && q.lock_arm) begin
                  d.locks[ee_blk(byte_in)] = 1'b1;
                end
              end
              default: d.fsm = S_DONE;
            endcase
          end
        end
      end
      S_READ: begin
        // Prefetch into FIFO; stalls when FIFO full
        if (fifo_ready) begin
          fifo_push = 1'b1;
          if (q.cmd == `SWL_OP_READ_CRC && q.page == 8'(`SWL_CRC_PAGE)) begin
            fifo_in = q.crc;
            d.crc   = 8'h00;
            d.page  = 8'h00;
          end else begin
            fifo_in = mem_read(q.addr);
            d.addr  = q.addr + 1'b1;
            d.crc   = crc_byte(q.crc, fifo_in);
            d.page  = q.page + 1'b1;
          end
        end
        if (bit_ev) begin
          d.bit_cnt = {4'd0, q.bit_cnt[2:0] + 3'd1};
          fifo_pop  = (q.bit_cnt[2:0] == 3'd7);
        end
      end
      S_WRITE: begin
        if (bit_ev) begin
          d.sh      = byte_in;
          d.bit_cnt = {4'd0, q.bit_cnt[2:0] + 3'd1};
          // Only whole bytes are stored
          if (q.bit_cnt[2:0] == 3'd7) begin
            d.addr = q.addr + 1'b1;
            if (ee_hit(q.addr)) begin
              if (!q.busy && !q.locks[ee_blk(q.addr)]) begin
                d.shadow[ee_idx(q.addr)] = byte_in;
              end
            end else if (ram_hit(q.addr)) begin
              d.ram[6'(q.addr - `SWL_RAM_BASE)] = byte_in;
            end else if (q.addr == `SWL_CTRL_ADDR) begin
              d.lock_arm  = byte_in[`SWL_ARM_BIT];
              d.arm_fresh = byte_in[`SWL_ARM_BIT];
            end
          end
        end
      end
      default: d.fsm = S_IDLE;
    endcase

    // ----------------------------------------
    // Copy timer, runs through any reset pulse
    // ----------------------------------------
    if (q.copy_pend && fall) begin
      d.copy_pend = 1'b0;
      d.busy      = 1'b1;
      d.copy_cnt  = '0;
    end
    if (q.busy) begin
      d.copy_cnt = q.copy_cnt + 1'b1;
      if (q.copy_cnt == cnt_t'(COPY_CYC - 1)) begin
        d.busy = 1'b0;
        for (int i = 0; i < `SWL_EE_BYTES; i++) begin
          if ((i >= `SWL_BLK0_SIZE) == q.copy_blk) begin
            d.cells[i] = q.shadow[i];
          end
        end
      end
    end

    // Long low overrides all but the copy timer; CRC result never consulted
    if (q.ln.low_cnt == cnt_t'(LOW0_CYC) && !q.ln.drv &&
        q.fsm != S_RSTL && q.fsm != S_PDL) begin
      d.fsm         = S_RSTL;
      d.ln.slot_act = 1'b0;
      d.bit_cnt     = '0;
      d.phase       = 2'd0;
      d.lock_ok     = 1'b0;
      fifo_flush    = 1'b1;
      fifo_push     = 1'b0;
      fifo_pop      = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      q          <= '0;
      q.fsm      <= S_IDLE;
      q.ln.sync1 <= 1'b1;
      q.ln.sync2 <= 1'b1;
      q.ln.prev  <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// >>> test/swl_host.sv
// Host side model: drives reset pulses and time slots on the line.
// Assumes the bench resolves the line with a pull-up from all pull enables.
module swl_host (
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  output logic      o_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pull = 1'b0;

  // ----------------------------------------
  // Line tasks
  // ----------------------------------------
  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    @(negedge i_ref_clk);
    o_pull = 1'b1;
    repeat (250) @(negedge i_ref_clk);
    o_pull = 1'b0;
    repeat (150) begin
      @(negedge i_ref_clk);
      if (!i_line) seen = 1'b1;
    end
  endtask

  // Slot of 70 cycles; zero holds low 60, well short of a reset pulse
  task automatic slot(input logic b, output logic r);
    @(negedge i_ref_clk);
    o_pull = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    if (b) o_pull = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    r = i_line;
    repeat (46) @(negedge i_ref_clk);
    o_pull = 1'b0;
    repeat (10) @(negedge i_ref_clk);
  endtask

  task automatic wr_byte(input logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) slot(d[i], r);
  endtask

  task automatic rd_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) slot(1'b1, d[i]);
  endtask
endmodule

// >>> test/swl_slave_monitor.sv
// Port checker for swl_slave.
// Assumes i_line carries the resolved line level.
module swl_slave_monitor #(
  parameter int LOW0_CYC = 200,
  parameter int HOLD_CYC = 40,
  parameter int PDH_CYC  = 20,
  parameter int PDL_CYC  = 100,
  parameter int COPY_CYC = 50
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_line,
  input wire logic o_line,
  input wire logic o_line_oe,
  input wire logic o_copy_busy
);
  localparam int PD_LO = PDH_CYC;
  localparam int PD_HI = PDH_CYC + 6;
  int low_q, high_q, oe_q, busy_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      low_q  <= 0;
      high_q <= 0;
      oe_q   <= 0;
      busy_q <= 0;
    end else begin
      low_q  <= i_line ? 0 : low_q + 1;
      high_q <= i_line ? high_q + 1 : 0;
      oe_q   <= o_line_oe ? oe_q + 1 : 0;
      busy_q <= o_copy_busy ? busy_q + 1 : 0;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_line_zero: assert property (o_line == 1'b0)
    else $error("line data not zero");
  chk_drive_cause: assert property ($rose(o_line_oe) |->
    (low_q inside {[1:8]}) || (high_q inside {[PD_LO:PD_HI]})) else $error("drive without cause");
  chk_presence_delay: assert property (
    ($rose(i_line) && low_q >= LOW0_CYC + 4) |-> ##[PD_LO:PD_HI] $rose(o_line_oe))
    else $error("presence late");
  chk_oe_width: assert property ($fell(o_line_oe) |->
    oe_q inside {[HOLD_CYC-1:HOLD_CYC+1], [PDL_CYC-1:PDL_CYC+1]}) else $error("drive width");
  chk_abandon_low: assert property ((low_q >= LOW0_CYC + 4) |-> !o_line_oe)
    else $error("drives during reset pulse");
  chk_busy_start: assert property ($rose(o_copy_busy) |-> low_q inside {[1:8]})
    else $error("busy not at fall");
  chk_busy_len: assert property ($fell(o_copy_busy) |->
    busy_q inside {[COPY_CYC:COPY_CYC+1]}) else $error("busy length");
  chk_reset_quiet: assert property (disable iff (1'b0) i_rst |=>
    !o_line_oe && !o_copy_busy) else $error("outputs after reset");

  cover property ($rose(o_copy_busy));
  cover property ($fell(o_line_oe) && oe_q > HOLD_CYC + 2);
  cover property ($fell(o_line_oe) && oe_q < HOLD_CYC + 2);
endmodule

bind swl_slave swl_slave_monitor #(.LOW0_CYC(LOW0_CYC), .HOLD_CYC(HOLD_CYC), .PDH_CYC(PDH_CYC),
  .PDL_CYC(PDL_CYC), .COPY_CYC(COPY_CYC)) swl_slave_monitor_inst (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_line(i_line), .o_line(o_line), .o_line_oe(o_line_oe),
  .o_copy_busy(o_copy_busy));

// >>> test/test_single_wire_slave_memory_access.sv
// Self-checking bench for swl_slave with a host model on the line.
// Assumes shortened timing parameters; line has a pull-up.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end
module test_single_wire_slave_memory_access;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  FAM = 8'h5A;             // Arbitrary value
  localparam logic [47:0] SER = 48'h0123_4567_89AB; // Arbitrary value
  logic        i_ref_clk, i_rst, line, drv_oe, dev_oe, busy, pres;
  logic [7:0]  v;
  logic [63:0] got;
  int          bad_count, checked;

  function automatic logic [7:0] crc_n(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction
  wire [63:0] exp_id = {crc_n({8'h00, SER, FAM}, 56), SER, FAM};
  assign line = !(dev_oe || drv_oe);

  swl_slave #(.LOW0_CYC(200), .SAMPLE_CYC(20), .HOLD_CYC(40), .PDH_CYC(20), .PDL_CYC(100),
    .COPY_CYC(4000)) swl_slave_inst (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_line(line), .o_line(), .o_line_oe(dev_oe), .o_copy_busy(busy));
  swl_host host_inst (.i_ref_clk(i_ref_clk), .i_line(line), .o_pull(drv_oe));

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic begin_op(input logic [7:0] op, input logic [7:0] a);
    host_inst.bus_reset(pres);
    `CHK(pres, 1'b1);
    host_inst.wr_byte(8'hCC);
    host_inst.wr_byte(op);
    host_inst.wr_byte(a);
  endtask
  task automatic rd_chk(input logic [7:0] e);
    host_inst.rd_byte(v);
    `CHK(v, e);
  endtask
  task automatic t_netaddr;
    `CHK(dev_oe, 1'b0);
    host_inst.bus_reset(pres);
    host_inst.wr_byte(8'h33);
    for (int i = 0; i < 8; i++) host_inst.rd_byte(got[8*i+:8]);
    `CHK(got, exp_id);
  endtask
  task automatic t_write_read;
    begin_op(8'h6C, 8'h1F);
    host_inst.wr_byte(8'hFF);
    host_inst.wr_byte(8'h5A);
    begin_op(8'h69, 8'h1F);
    rd_chk(8'h40);
    rd_chk(8'h5A);
    begin_op(8'h6C, 8'h40);
    host_inst.wr_byte(8'hC3);
    for (int i = 0; i < 4; i++) host_inst.slot(1'b1, v[0]);
    begin_op(8'h69, 8'h40);
    rd_chk(8'hC3);
    rd_chk(8'h00);
  endtask
  task automatic t_copy;
    begin_op(8'hB8, 8'h20);
    begin_op(8'h69, 8'h20);
    rd_chk(8'h00);
    begin_op(8'h6C, 8'h20);
    host_inst.wr_byte(8'h5A);
    begin_op(8'h48, 8'h20);
    host_inst.slot(1'b1, v[0]);
    `CHK(busy, 1'b1);
    begin_op(8'h6C, 8'h21);
    host_inst.wr_byte(8'h77);
    for (int n = 0; n < 5000 && busy; n++) @(negedge i_ref_clk);
    `CHK(busy, 1'b0);
    begin_op(8'hB8, 8'h20);
    begin_op(8'h69, 8'h20);
    rd_chk(8'h5A);
    rd_chk(8'h00);
  endtask
  task automatic t_match;
    for (int k = 0; k < 2; k++) begin
      host_inst.bus_reset(pres);
      host_inst.wr_byte(8'h55);
      for (int i = 0; i < 8; i++)
        host_inst.wr_byte(exp_id[8*i+:8] ^ ((k == 0 && i == 3) ? 8'h10 : 8'h00));
      host_inst.wr_byte(8'h69);
      host_inst.wr_byte(8'h40);
      rd_chk(k ? 8'hC3 : 8'hFF);
    end
  endtask
  task automatic t_search;
    logic a, b;
    host_inst.bus_reset(pres);
    host_inst.wr_byte(8'hF0);
    for (int i = 0; i < 10; i++) begin
      host_inst.slot(1'b1, a);
      host_inst.slot(1'b1, b);
      `CHK({a, b}, (i < 9) ? {exp_id[i], !exp_id[i]} : 2'b11);
      host_inst.slot(exp_id[i] ^ (i == 8), a);
    end
  endtask
  task automatic t_crc;
    begin_op(8'h66, 8'h40);
    for (int i = 0; i < 8; i++) rd_chk(i ? 8'h00 : 8'hC3);
    host_inst.rd_byte(v);
    `CHK(v, crc_n(64'hC3, 64));
    rd_chk(8'h00);
  endtask
  task automatic t_lock;
    begin_op(8'h6C, 8'h1F);
    host_inst.wr_byte(8'h40);
    begin_op(8'h6A, 8'h80);
    host_inst.wr_byte(8'h6A);
    host_inst.wr_byte(8'h20);
    begin_op(8'h6C, 8'h80);
    host_inst.wr_byte(8'h99);
    begin_op(8'h69, 8'h1F);
    rd_chk(8'h42);
    begin_op(8'h69, 8'h80);
    rd_chk(8'h00);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    bad_count = 0;
    checked = 0;
    i_rst = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    t_netaddr;
    t_write_read;
    t_copy;
    t_match;
    t_search;
    t_crc;
    t_lock;
    give_verdict;
  end
  // Run needs about 80k cycles
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    bad_count++;
    give_verdict;
  end
endmodule
